// ### include/pwrseq_pkg.sv
// Package of shared constants and types for the power sequencer ends.
package pwrseq_pkg;

    // -------------------------------------------------------------
    // Clock and timing
    // -------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int FAIL_REPEAT_MS = 1000;
    localparam int FAIL_TIMEOUT_S = 50;
    localparam int FAIL_REPEAT_CYC = FAIL_REPEAT_MS * 1000 * CLK_MHZ;
    localparam int FAIL_TIMEOUT_REPEATS = FAIL_TIMEOUT_S * 1000 / FAIL_REPEAT_MS;

    // -------------------------------------------------------------
    // Memory map selected on power-up
    // -------------------------------------------------------------
    localparam logic [15:0] START_ADDR = 16'h0000;
    localparam logic [15:0] ROM_LAST = 16'h7fff;
    localparam logic [15:0] RAM_FIRST = 16'h8000;
    localparam logic BANK_SYSTEM = 1'b1;
    localparam logic BANK_OTHER = 1'b0;

    // -------------------------------------------------------------
    // Start sources, interrupt causes and mode flag values
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_POWER_SW = 2'h0,
        SRC_WAKE = 2'h1,
        SRC_MAIN_RESET = 2'h2,
        SRC_CTRL_RESET = 2'h3
    } pwrseq_src_t;

    typedef enum logic [1:0] {
        IRQ_NONE = 2'h0,
        IRQ_SW_ON = 2'h1,
        IRQ_SW_OFF = 2'h2,
        IRQ_PWR_FAIL = 2'h3
    } pwrseq_cause_t;

    localparam logic MODE_RESTART = 1'b0;
    localparam logic MODE_CONTINUE = 1'b1;

endpackage

// ### include/pwrseq_if.sv
// Link between the power controller and the host processor.
`timescale 1ns/100ps
interface pwrseq_if;
    import pwrseq_pkg::*;

    logic host_power;
    logic bank_sel;
    logic host_start;
    logic [15:0] start_addr;
    pwrseq_src_t start_src;
    logic irq;
    pwrseq_cause_t irq_cause;
    logic irq_ack;
    logic shutdown_cmd;

    modport ctrl (
        output host_power, bank_sel, host_start, start_addr, start_src, irq, irq_cause,
        input irq_ack, shutdown_cmd
    );
    modport host (
        input host_power, bank_sel, host_start, start_addr, start_src, irq, irq_cause,
        output irq_ack, shutdown_cmd
    );
endinterface

// ### rtl/pwrseq_ctrl.sv
// Power controller end: sequences host supply, start and power events.
// Notes on behaviour
// - Power switch on or wake powers up.
// - Supply, then system bank, then start zero.
// - Either reset switch also starts at zero.
// - Report which of four sources started.
// - Interrupt host on each power switch change while on.
// - Low battery raises power-fail interrupt.
// - Host sends shut-down command to power off.
// - Host stops peripherals before shut-down command.
// - Host warm boots or resumes by mode.
// - Host keeps restart/continue mode flag.
// - Host handles alarm and wake starts.
// - Main reset: reset processing, cold boot.
// - Controller reset: reset processing, initialize and cold boot together.
// - Off-state wake active keeps the mode flag unchanged.
// - Menu shutdown always uses restart mode; with off-state wake active the code keeps the flag unchanged.
// - Display shutdown restores state first.
// - Repeat power-fail interrupt every second.
// - No shut-down in time: force off, reset path.
`timescale 1ns/100ps
module pwrseq_ctrl
    import pwrseq_pkg::*;
#(
    parameter int REPEAT_CYC = FAIL_REPEAT_CYC,
    parameter int TIMEOUT_REPEATS = FAIL_TIMEOUT_REPEATS
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Switches and sensors.
    input wire logic power_sw,
    input wire logic wake_evt,
    input wire logic main_reset_sw,
    input wire logic ctrl_reset_sw,
    input wire logic batt_low,
    // Host link.
    pwrseq_if.ctrl lnk,
    // Status.
    output logic forced_off
);

    // -------------------------------------------------------------
    // Sequencer states
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_SUPPLY = 3'h1,
        ST_BANK = 3'h2,
        ST_START = 3'h3,
        ST_ON = 3'h4
    } pwrseq_st_t;

    pwrseq_st_t st_ff, nxt_st;
    logic pwr_ff, nxt_pwr;
    logic bank_ff, nxt_bank;
    logic start_ff, nxt_start;
    pwrseq_src_t src_ff, nxt_src;
    logic irq_ff, nxt_irq;
    pwrseq_cause_t cause_ff, nxt_cause;
    logic sw_ff, nxt_sw;
    logic fail_ff, nxt_fail;
    logic [31:0] tick_ff, nxt_tick;
    logic [31:0] rep_ff, nxt_rep;
    logic forced_ff, nxt_forced;

    // -------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_pwr = pwr_ff;
        nxt_bank = bank_ff;
        nxt_start = 1'b0;
        nxt_src = src_ff;
        nxt_irq = irq_ff;
        nxt_cause = cause_ff;
        nxt_sw = power_sw;
        nxt_fail = fail_ff;
        nxt_tick = tick_ff;
        nxt_rep = rep_ff;
        nxt_forced = forced_ff;
        if (lnk.irq_ack) begin
            nxt_irq = 1'b0;
            nxt_cause = IRQ_NONE;
        end
        unique case (st_ff)
            ST_OFF: begin
                if (ctrl_reset_sw) begin
                    nxt_src = SRC_CTRL_RESET;
                    nxt_st = ST_SUPPLY;
                end else if (main_reset_sw) begin
                    nxt_src = SRC_MAIN_RESET;
                    nxt_st = ST_SUPPLY;
                end else if (power_sw && !sw_ff) begin
                    nxt_src = forced_ff ? SRC_CTRL_RESET : SRC_POWER_SW;
                    nxt_st = ST_SUPPLY;
                end else if (wake_evt) begin
                    nxt_src = forced_ff ? SRC_CTRL_RESET : SRC_WAKE;
                    nxt_st = ST_SUPPLY;
                end
            end
            ST_SUPPLY: begin
                nxt_pwr = 1'b1;
                nxt_forced = 1'b0;
                nxt_st = ST_BANK;
            end
            ST_BANK: begin
                nxt_bank = BANK_SYSTEM;
                nxt_st = ST_START;
            end
            ST_START: begin
                nxt_start = 1'b1;
                nxt_fail = 1'b0;
                nxt_st = ST_ON;
            end
            ST_ON: begin
                if (ctrl_reset_sw || main_reset_sw) begin
                    nxt_src = ctrl_reset_sw ? SRC_CTRL_RESET : SRC_MAIN_RESET;
                    nxt_st = ST_BANK;
                end else if (lnk.shutdown_cmd) begin
                    nxt_pwr = 1'b0;
                    nxt_bank = BANK_OTHER;
                    nxt_irq = 1'b0;
                    nxt_cause = IRQ_NONE;
                    nxt_st = ST_OFF;
                end else if (fail_ff && rep_ff >= 32'(TIMEOUT_REPEATS)) begin
                    nxt_pwr = 1'b0;
                    nxt_bank = BANK_OTHER;
                    nxt_forced = 1'b1;
                    nxt_irq = 1'b0;
                    nxt_cause = IRQ_NONE;
                    nxt_st = ST_OFF;
                end else if (power_sw != sw_ff) begin
                    nxt_irq = 1'b1;
                    nxt_cause = power_sw ? IRQ_SW_ON : IRQ_SW_OFF;
                end else if (batt_low && !fail_ff) begin
                    nxt_fail = 1'b1;
                    nxt_irq = 1'b1;
                    nxt_cause = IRQ_PWR_FAIL;
                    nxt_tick = 32'h0000_0000;
                    nxt_rep = 32'h0000_0000;
                end else if (fail_ff) begin
                    if (tick_ff >= 32'(REPEAT_CYC - 1)) begin
                        nxt_tick = 32'h0000_0000;
                        nxt_rep = rep_ff + 32'h0000_0001;
                        if (batt_low) begin
                            nxt_irq = 1'b1;
                            nxt_cause = IRQ_PWR_FAIL;
                        end
                    end else begin
                        nxt_tick = tick_ff + 32'h0000_0001;
                    end
                end
            end
            default: nxt_st = ST_OFF;
        endcase
        // A shut-down command while off changes nothing.
    end

    // -------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= ST_OFF;
            pwr_ff <= 1'b0;
            bank_ff <= BANK_OTHER;
            start_ff <= 1'b0;
            src_ff <= SRC_POWER_SW;
            irq_ff <= 1'b0;
            cause_ff <= IRQ_NONE;
            sw_ff <= 1'b0;
            fail_ff <= 1'b0;
            tick_ff <= 32'h0000_0000;
            rep_ff <= 32'h0000_0000;
            forced_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            pwr_ff <= nxt_pwr;
            bank_ff <= nxt_bank;
            start_ff <= nxt_start;
            src_ff <= nxt_src;
            irq_ff <= nxt_irq;
            cause_ff <= nxt_cause;
            sw_ff <= nxt_sw;
            fail_ff <= nxt_fail;
            tick_ff <= nxt_tick;
            rep_ff <= nxt_rep;
            forced_ff <= nxt_forced;
        end
    end

    assign lnk.host_power = pwr_ff;
    assign lnk.bank_sel = bank_ff;
    assign lnk.host_start = start_ff;
    assign lnk.start_addr = START_ADDR;
    assign lnk.start_src = src_ff;
    assign lnk.irq = irq_ff;
    assign lnk.irq_cause = cause_ff;
    assign forced_off = forced_ff;

endmodule

// ### rtl/pwrseq_host.sv
// Host end: start dispatch, mode flag and shut-down protocol.
`timescale 1ns/100ps
module pwrseq_host
    import pwrseq_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Link to controller.
    pwrseq_if.host lnk,
    // Software controls.
    input wire logic continue_key,
    input wire logic sw_power_off,
    input wire logic sw_power_mode,
    input wire logic alarm_pending,
    input wire logic alarm_power_off,
    input wire logic wake_is_second,
    input wire logic menu_active,
    input wire logic display_active,
    input wire logic offstate_wake_active,
    input wire logic periph_busy,
    // Actions.
    output logic periph_off,
    output logic warm_boot_entry,
    output logic cold_boot_entry,
    output logic resume,
    output logic sys_init,
    output logic reset_proc,
    output logic wake_branch,
    output logic display_restore,
    output logic mode_flag
);

    logic mode_ff, nxt_mode;
    logic pend_ff, nxt_pend;
    logic cmd_ff, nxt_cmd;
    logic poff_ff, nxt_poff;
    logic [6:0] act_ff, nxt_act;
    logic ack_ff, nxt_ack;

    // -------------------------------------------------------------
    // Dispatch and shut-down
    // -------------------------------------------------------------
    always_comb begin
        nxt_mode = mode_ff;
        nxt_pend = pend_ff;
        nxt_cmd = 1'b0;
        nxt_poff = 1'b0;
        nxt_act = 7'h00;
        nxt_ack = 1'b0;
        if (lnk.host_start) begin
            unique case (lnk.start_src)
                SRC_MAIN_RESET: nxt_act = 7'h06;
                SRC_CTRL_RESET: nxt_act = 7'h0e;
                SRC_WAKE: begin
                    if (alarm_pending && alarm_power_off) begin
                        nxt_pend = 1'b1;
                    end else if (wake_is_second && !alarm_pending) begin
                        nxt_act = 7'h40;
                    end else begin
                        nxt_act = (mode_ff == MODE_CONTINUE) ? 7'h20 : 7'h01;
                    end
                end
                SRC_POWER_SW: nxt_act = (mode_ff == MODE_CONTINUE) ? 7'h20 : 7'h01;
            endcase
        end else if (lnk.irq && lnk.host_power) begin
            nxt_ack = 1'b1;
            if (lnk.irq_cause == IRQ_SW_OFF) begin
                nxt_pend = 1'b1;
                nxt_mode = continue_key ? MODE_CONTINUE : MODE_RESTART;
            end else if (lnk.irq_cause == IRQ_PWR_FAIL) begin
                nxt_pend = 1'b1;
                nxt_mode = MODE_CONTINUE;
            end
        end else if (sw_power_off && lnk.host_power) begin
            nxt_pend = 1'b1;
            nxt_mode = sw_power_mode;
        end else if (pend_ff && lnk.host_power) begin
            if (menu_active) begin
                nxt_mode = MODE_RESTART;
            end
            if (display_active) begin
                nxt_act = 7'h10;
            end else if (periph_busy) begin
                nxt_poff = 1'b1;
            end else begin
                nxt_cmd = 1'b1;
                nxt_pend = 1'b0;
            end
        end
        if (!lnk.host_power) begin
            nxt_pend = 1'b0;
        end
        if (offstate_wake_active) begin
            nxt_mode = mode_ff;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_ff <= MODE_RESTART;
            pend_ff <= 1'b0;
            cmd_ff <= 1'b0;
            poff_ff <= 1'b0;
            act_ff <= 7'h00;
            ack_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            pend_ff <= nxt_pend;
            cmd_ff <= nxt_cmd;
            poff_ff <= nxt_poff;
            act_ff <= nxt_act;
            ack_ff <= nxt_ack;
        end
    end

    assign lnk.shutdown_cmd = cmd_ff;
    assign lnk.irq_ack = ack_ff;
    assign periph_off = poff_ff;
    assign warm_boot_entry = act_ff[0];
    assign reset_proc = act_ff[1];
    assign cold_boot_entry = act_ff[2];
    assign sys_init = act_ff[3];
    assign display_restore = act_ff[4];
    assign resume = act_ff[5];
    assign wake_branch = act_ff[6];
    assign mode_flag = mode_ff;

endmodule

// ### verif/pwrseq_props.sv
// Checker of the link between the power controller and the host.
`timescale 1ns/100ps
module pwrseq_props
    import pwrseq_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Link signals.
    input wire logic host_power,
    input wire logic bank_sel,
    input wire logic host_start,
    input wire logic [15:0] start_addr,
    input pwrseq_src_t start_src,
    input wire logic irq,
    input pwrseq_cause_t irq_cause,
    input wire logic irq_ack,
    input wire logic shutdown_cmd
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_start_map; host_start |-> start_addr == START_ADDR && bank_sel == BANK_SYSTEM && host_power; endproperty
    a_start_map: assert property (p_start_map) else $error("start without map or supply");
    property p_power_seq; $rose(host_power) |=> bank_sel ##1 host_start; endproperty
    a_power_seq: assert property (p_power_seq) else $error("power-up order broken");
    property p_bank_late; $rose(bank_sel) |-> $past(host_power); endproperty
    a_bank_late: assert property (p_bank_late) else $error("bank before supply");
    property p_off_clears; shutdown_cmd && host_power |=> !host_power && !bank_sel && !irq; endproperty
    a_off_clears: assert property (p_off_clears) else $error("shut-down not obeyed");
    property p_off_ignore; !host_power && shutdown_cmd |=> !host_power; endproperty
    a_off_ignore: assert property (p_off_ignore) else $error("shut-down while off acted");
    property p_irq_hold; irq && !irq_ack |=> irq || !host_power; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped before ack");
    property p_irq_cause; irq |-> irq_cause != IRQ_NONE; endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
    property p_irq_off; !host_power |-> !irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while off");
    property p_ack_prompt; $rose(irq) |-> ##[1:4] (irq_ack || !host_power); endproperty
    a_ack_prompt: assert property (p_ack_prompt) else $error("irq not acknowledged");
endmodule

// ### verif/power_on_off_sequencer_test.sv
// Self-checking bench joining both sequencer ends.
`timescale 1ns/100ps
module power_on_off_sequencer_test
    import pwrseq_pkg::*;
();
    localparam int RC = 20;
    localparam int TR = 3;
    typedef struct {logic [1:0] ev; logic sec; pwrseq_src_t src; logic [7:0] act;} pwrseq_row_t;
    pwrseq_row_t rows [5] = '{'{2'h0, 1'b0, SRC_POWER_SW, 8'h80}, '{2'h1, 1'b0, SRC_WAKE, 8'h80},
        '{2'h1, 1'b1, SRC_WAKE, 8'h04}, '{2'h2, 1'b0, SRC_MAIN_RESET, 8'h48},
        '{2'h3, 1'b0, SRC_CTRL_RESET, 8'h58}};
    logic clk, rst_b, power_sw, wake_evt, main_reset_sw, ctrl_reset_sw, batt_low, forced_off;
    logic continue_key, sw_power_off, sw_power_mode, alarm_pending, alarm_power_off, wake_is_second;
    logic menu_active, display_active, offstate_wake_active, periph_busy, mode_flag;
    logic warm, cold, resume, sys_init, reset_proc, wake_branch, display_restore, periph_off;
    logic [7:0] act;
    logic [7:0] seen;
    int nfail, err_count, num_checks, i;
    assign act = {warm, cold, resume, sys_init, reset_proc, wake_branch, display_restore, periph_off};

    pwrseq_if lnk();
    pwrseq_ctrl #(.REPEAT_CYC(RC), .TIMEOUT_REPEATS(TR)) u_pwrseq_ctrl (.clk(clk), .rst_b(rst_b),
        .power_sw(power_sw), .wake_evt(wake_evt), .main_reset_sw(main_reset_sw),
        .ctrl_reset_sw(ctrl_reset_sw), .batt_low(batt_low), .lnk(lnk), .forced_off(forced_off));
    pwrseq_host u_pwrseq_host (.clk(clk), .rst_b(rst_b), .lnk(lnk), .continue_key(continue_key),
        .sw_power_off(sw_power_off), .sw_power_mode(sw_power_mode), .alarm_pending(alarm_pending),
        .alarm_power_off(alarm_power_off), .wake_is_second(wake_is_second), .menu_active(menu_active),
        .display_active(display_active), .offstate_wake_active(offstate_wake_active),
        .periph_busy(periph_busy), .periph_off(periph_off), .warm_boot_entry(warm), .cold_boot_entry(cold),
        .resume(resume), .sys_init(sys_init), .reset_proc(reset_proc), .wake_branch(wake_branch),
        .display_restore(display_restore), .mode_flag(mode_flag));
    pwrseq_props u_pwrseq_props (.clk(clk), .rst_b(rst_b), .host_power(lnk.host_power),
        .bank_sel(lnk.bank_sel), .host_start(lnk.host_start), .start_addr(lnk.start_addr),
        .start_src(lnk.start_src), .irq(lnk.irq), .irq_cause(lnk.irq_cause), .irq_ack(lnk.irq_ack),
        .shutdown_cmd(lnk.shutdown_cmd));

    // ------------------------------------------------------------
    // Clock, monitors and helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        seen <= seen | act;
        if (lnk.irq_ack === 1'b1 && lnk.irq_cause === IRQ_PWR_FAIL) nfail <= nfail + 1;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic start(input logic [1:0] ev, input logic sec, input pwrseq_src_t src, input logic [7:0] ex);
        seen = 8'h00;
        wake_is_second = sec;
        case (ev)
            2'h0: power_sw = 1'b1;
            2'h1: wake_evt = 1'b1;
            2'h2: main_reset_sw = 1'b1;
            default: ctrl_reset_sw = 1'b1;
        endcase
        step(1);
        {wake_evt, main_reset_sw, ctrl_reset_sw} = 3'h0;
        for (i = 0; i < 12 && lnk.host_start !== 1'b1; i++) step(1);
        chk("host_start", 16'h0001, lnk.host_start);
        chk("start_src", src, lnk.start_src);
        step(6);
        chk("host action", ex, seen & ex);
    endtask
    task automatic go_off(input logic md, input logic ex, input logic dsp = 1'b0);
        seen = 8'h00;
        sw_power_mode = md;
        sw_power_off = 1'b1;
        periph_busy = 1'b1;
        display_active = dsp;
        step(1);
        sw_power_off = 1'b0;
        step(1);
        display_active = 1'b0;
        step(1);
        periph_busy = 1'b0;
        for (i = 0; i < 30 && lnk.host_power !== 1'b0; i++) step(1);
        chk("host_power off", 16'h0000, lnk.host_power);
        chk("periph_off", 16'h0001, seen[0]);
        chk("display_restore", dsp, seen[1]);
        chk("mode_flag", ex, mode_flag);
        power_sw = 1'b0;
        step(2);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_count++;
        final_report();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_b, power_sw, wake_evt, main_reset_sw, ctrl_reset_sw, batt_low, continue_key} = '0;
        {sw_power_off, sw_power_mode, alarm_pending, alarm_power_off, wake_is_second} = '0;
        {menu_active, display_active, offstate_wake_active, periph_busy} = '0;
        {seen, nfail, err_count, num_checks} = '0;
        step(8);
        chk("reset power", 16'h0000, lnk.host_power);
        rst_b = 1'b1;
        step(4);
        chk("idle power", 16'h0000, lnk.host_power);
        foreach (rows[k]) begin
            start(rows[k].ev, rows[k].sec, rows[k].src, rows[k].act);
            go_off(MODE_RESTART, MODE_RESTART);
        end
        start(2'h0, 1'b0, SRC_POWER_SW, 8'h80);
        go_off(MODE_CONTINUE, MODE_CONTINUE);
        start(2'h0, 1'b0, SRC_POWER_SW, 8'h20);
        menu_active = 1'b1;
        go_off(MODE_CONTINUE, MODE_RESTART);
        menu_active = 1'b0;
        start(2'h2, 1'b0, SRC_MAIN_RESET, 8'h48);
        power_sw = 1'b1;
        for (i = 0; i < 10 && lnk.irq !== 1'b1; i++) step(1);
        chk("irq_cause on", IRQ_SW_ON, lnk.irq_cause);
        step(6);
        chk("irq after ack", 16'h0000, lnk.irq);
        continue_key = 1'b1;
        power_sw = 1'b0;
        for (i = 0; i < 10 && lnk.irq !== 1'b1; i++) step(1);
        chk("irq_cause off", IRQ_SW_OFF, lnk.irq_cause);
        for (i = 0; i < 40 && lnk.host_power !== 1'b0; i++) step(1);
        chk("switch off power", 16'h0000, lnk.host_power);
        chk("switch off mode", MODE_CONTINUE, mode_flag);
        continue_key = 1'b0;
        step(2);
        start(2'h0, 1'b0, SRC_POWER_SW, 8'h20);
        batt_low = 1'b1;
        for (i = 0; i < 10 && lnk.irq !== 1'b1; i++) step(1);
        chk("irq_cause fail", IRQ_PWR_FAIL, lnk.irq_cause);
        for (i = 0; i < 40 && lnk.host_power !== 1'b0; i++) step(1);
        chk("fail mode", MODE_CONTINUE, mode_flag);
        chk("not forced", 16'h0000, forced_off);
        {batt_low, power_sw} = 2'h0;
        step(2);
        start(2'h0, 1'b0, SRC_POWER_SW, 8'h20);
        periph_busy = 1'b1;
        batt_low = 1'b1;
        nfail = 0;
        for (i = 0; i < 300 && lnk.host_power !== 1'b0; i++) step(1);
        chk("late force", 16'h0001, i >= TR * RC && i <= TR * RC + 2);
        chk("forced power", 16'h0000, lnk.host_power);
        chk("forced_off", 16'h0001, forced_off);
        chk("fail repeats", 16'h0001, nfail >= TR);
        {batt_low, periph_busy, power_sw} = 3'h0;
        step(2);
        start(2'h0, 1'b0, SRC_CTRL_RESET, 8'h40);
        chk("forced cleared", 16'h0000, forced_off);
        go_off(MODE_RESTART, MODE_RESTART);
        start(2'h0, 1'b0, SRC_POWER_SW, 8'h80);
        offstate_wake_active = 1'b1;
        go_off(MODE_CONTINUE, MODE_RESTART);
        offstate_wake_active = 1'b0;
        {alarm_pending, alarm_power_off} = 2'h3;
        start(2'h1, 1'b0, SRC_WAKE, 8'h00);
        chk("alarm action", 16'h0000, seen);
        chk("alarm power", 16'h0000, lnk.host_power);
        alarm_power_off = 1'b0;
        start(2'h1, 1'b1, SRC_WAKE, 8'h80);
        go_off(MODE_RESTART, MODE_RESTART, 1'b1);
        {alarm_pending, wake_is_second} = 2'h0;
        start(2'h0, 1'b0, SRC_POWER_SW, 8'h80);
        {rst_b, power_sw} = 2'h0;
        step(2);
        chk("reset mid power", 16'h0000, lnk.host_power);
        chk("reset mid bank", 16'h0000, lnk.bank_sel);
        rst_b = 1'b1;
        step(2);
        chk("reset mid idle", 16'h0000, lnk.host_power);
        sw_power_off = 1'b1;
        step(1);
        sw_power_off = 1'b0;
        step(10);
        chk("off stays off", 16'h0000, lnk.host_power);
        final_report();
    end
endmodule
